// ===== verilog/motor_bridge_pkg.sv
// Types, constants and helper functions of the motor bridge output control
package motor_bridge_pkg;
  typedef enum logic [2:0] {
    MODE_LOW, MODE_HIGH, MODE_FLOAT, MODE_PWM_HL, MODE_PWM_FL, MODE_PWM_HF
  } mode_t;

  typedef struct packed {
    mode_t mode_p;
    mode_t mode_n;
    logic ext_src;
    logic [7:0] duty;
    logic [1:0] oc_off;
  } bridge_cfg_t;

  typedef struct packed {
    logic fast_decay;
    logic [1:0] off_sel;
    logic [1:0] blank_sel;
    logic [3:0] vref;
    logic dir;
    logic half_step;
    logic clk_from_aux;
  } stepper_cfg_t;

  typedef struct packed {
    logic [7:0] base;
    logic [7:0] high;
    logic [7:0] low;
    logic to_pin;
  } aux_pwm_cfg_t;

  typedef struct packed {
    logic enable;
    logic [7:0] duty;
    logic [3:0] vref;
  } switcher_cfg_t;

  typedef struct packed {
    logic enable;
    logic [5:0] code;
    logic [1:0] lsb_sel;
    logic [1:0] fs_sel;
  } dac_cfg_t;

  localparam int BRIDGES = 4;
  localparam int CLK_NS = 25;
  localparam int OFF_UNIT_NS = 1000;
  localparam int OFF_UNIT_CYC = (OFF_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLANK_UNIT_NS = 250;
  localparam int BLANK_UNIT_CYC = (BLANK_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] DUTY_RESET = 8'h00;

  // Off or blank time in cycles: (select + 1) units
  function automatic logic [7:0] unit_cycles(logic [1:0] sel, int unit);
    unit_cycles = 8'((int'(sel) + 1) * unit);
  endfunction : unit_cycles

  // Half-bridge switch request {high, low} for a mode and PWM phase
  function automatic logic [1:0] half_drive(mode_t m, logic ph);
    unique case (m)
      MODE_LOW: half_drive = 2'b01;
      MODE_HIGH: half_drive = 2'b10;
      MODE_FLOAT: half_drive = 2'b00;
      MODE_PWM_HL: half_drive = ph ? 2'b10 : 2'b01;
      MODE_PWM_FL: half_drive = ph ? 2'b00 : 2'b01;
      MODE_PWM_HF: half_drive = ph ? 2'b10 : 2'b00;
      default: half_drive = 2'b00;
    endcase
  endfunction : half_drive

  // Half-step coil current {on, positive} for position and coil
  function automatic logic [1:0] step_phase(logic [2:0] pos, logic coil);
    logic [2:0] p;
    p = coil ? 3'(pos - 3'h2) : pos;
    unique case (p)
      3'h0, 3'h1, 3'h7: step_phase = 2'b11;
      3'h3, 3'h4, 3'h5: step_phase = 2'b10;
      default: step_phase = 2'b00;
    endcase
  endfunction : step_phase
endpackage : motor_bridge_pkg

// ===== verilog/motor_bridge_output_control.sv
// Bridge output control, stepper sequencer, aux PWM, switcher and DAC enables
`timescale 1ns/1ps
//
// Function
// - Bridge outputs float after reset until their pair is enabled.
// - Each half-bridge offers low, high, float and three PWM alternating modes.
// - Bridge PWM comes from the internal generator or an external input, duty set.
// - Bridges 1-2 take an overcurrent level, all bridges a selectable off-time.
// - With bridges 1-2 paralleled, both follow bridge 1 logic.
// - With bridges 3-4 paralleled, both follow bridge 3 logic.
// - Duty resets to zero; the host enables the pair then sets a nonzero duty.
// - The stepper controller takes all four halves of bridges 3-4 when selected.
// - Each rising edge of the step clock, from the step clock pin or aux PWM, advances the sequence.
// - Aux PWM 3 has programmable high, low and base times and can reach a pin.
// - The switcher controller is off until enabled, duty and reference set.
// - The 6-bit current sink DAC sinks on its pin only while enabled.
// - Low power floats all bridges and freezes the PWM, aux PWM and overcurrent off-time counters.
module motor_bridge_output_control #(
  parameter int OC_LEVEL_W = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] pair_en,
  input wire logic parallel_12,
  input wire logic parallel_34,
  input wire logic stepper_sel,
  input wire logic low_power,
  input wire motor_bridge_pkg::bridge_cfg_t [3:0] bridge_cfg,
  input wire logic [3:0] ext_pwm,
  input wire logic [3:0] oc_trip,
  input wire logic [1:0][OC_LEVEL_W-1:0] oc_level_set,
  input wire motor_bridge_pkg::stepper_cfg_t stepper_cfg,
  input wire logic [1:0] stepper_sense,
  input wire logic step_clock_pin,
  input wire motor_bridge_pkg::aux_pwm_cfg_t aux_cfg,
  input wire motor_bridge_pkg::switcher_cfg_t switcher_cfg,
  input wire motor_bridge_pkg::dac_cfg_t dac_cfg,
  output logic [7:0] hs_on,
  output logic [7:0] ls_on,
  output logic [1:0][OC_LEVEL_W-1:0] oc_level,
  output logic [3:0] stepper_vref,
  output logic timed_auxiliary_pwm_button,
  output logic aux_pin_oe,
  output logic switcher_controller_output,
  output logic [3:0] switcher_vref,
  output logic dac_sink_pin_enable,
  output logic [5:0] dac_code,
  output logic [1:0] dac_lsb_sel,
  output logic [1:0] dac_fs_sel
);
  if (OC_LEVEL_W < 1) begin : g_bad_width
    $error("OC_LEVEL_W must be at least 1");
  end

  logic [7:0] pwm_cnt, next_pwm_cnt;
  logic step_prev, next_step_prev;
  logic [2:0] pos, next_pos;
  logic [7:0] presc, next_presc, pc, next_pc;
  logic next_aux;
  logic [7:0] next_hs, next_ls, want_hs, want_ls, en_mask;
  logic [3:0] ph;
  logic [3:0] oc_busy;
  logic step_src, step_rise, tick, last;

  // Step clock source and edge detect
  assign step_src = stepper_cfg.clk_from_aux ? timed_auxiliary_pwm_button : step_clock_pin;
  assign step_rise = step_src & ~step_prev;
  assign tick = presc >= aux_cfg.base;

  for (genvar i = 0; i < motor_bridge_pkg::BRIDGES; i++) begin : g_bridge
    localparam int P = i - (i % 2);
    localparam int Q = P + 1;
    logic [7:0] duty, next_duty, oc_cnt, next_oc_cnt;
    logic use_p, pair_on;
    motor_bridge_pkg::bridge_cfg_t sc;
    logic sph, soff;

    assign pair_on = (i < 2) ? parallel_12 : parallel_34;
    assign use_p = pair_on && (i != P);
    assign en_mask[2*i+1:2*i] = {2{pair_en[i/2] & ~low_power}};
    // Internal or external PWM phase
    assign ph[i] = bridge_cfg[i].ext_src ? ext_pwm[i] : (pwm_cnt < duty);
    assign oc_busy[i] = oc_cnt != 8'h00;

    // Duty capture and overcurrent off-time, a new trip reloads
    always_comb begin
      next_duty = bridge_cfg[i].duty;
      next_oc_cnt = oc_cnt;
      if (oc_trip[i]) begin
        next_oc_cnt = motor_bridge_pkg::unit_cycles(bridge_cfg[i].oc_off,
          motor_bridge_pkg::OFF_UNIT_CYC);
      end else if (oc_busy[i] && !low_power) begin
        next_oc_cnt = oc_cnt - 8'h01;
      end
    end
    always_ff @(posedge clk) begin
      if (!nrst) begin
        duty <= motor_bridge_pkg::DUTY_RESET;
        oc_cnt <= 8'h00;
      end else begin
        duty <= next_duty;
        oc_cnt <= next_oc_cnt;
      end
    end

    // Paired bridge follows its leader's config and phase; off-time protection is shared by the pair
    assign sc = use_p ? bridge_cfg[P] : bridge_cfg[i];
    assign sph = use_p ? ph[P] : ph[i];
    // Paired bridges both float while either one sits in its off-time
    assign soff = pair_on ? (oc_busy[P] | oc_busy[Q]) : oc_busy[i];

    if (i >= 2) begin : g_step
      localparam logic C = 1'(i - 2);
      logic chop_off, next_chop_off;
      logic [7:0] tmr, next_tmr;
      logic [1:0] sp;
      // Chopper: blank after a step, trip on sense, then decay off-time
      always_comb begin
        next_chop_off = chop_off;
        next_tmr = tmr;
        if (step_rise) begin
          next_chop_off = 1'b0;
          next_tmr = motor_bridge_pkg::unit_cycles(stepper_cfg.blank_sel,
            motor_bridge_pkg::BLANK_UNIT_CYC);
        end else if (tmr != 8'h00) begin
          next_tmr = tmr - 8'h01;
        end else if (chop_off) begin
          next_chop_off = 1'b0;
          next_tmr = motor_bridge_pkg::unit_cycles(stepper_cfg.blank_sel,
            motor_bridge_pkg::BLANK_UNIT_CYC);
        end else if (stepper_sense[C]) begin
          next_chop_off = 1'b1;
          next_tmr = motor_bridge_pkg::unit_cycles(stepper_cfg.off_sel,
            motor_bridge_pkg::OFF_UNIT_CYC);
        end
      end
      always_ff @(posedge clk) begin
        if (!nrst) begin
          chop_off <= 1'b0;
          tmr <= 8'h00;
        end else begin
          chop_off <= next_chop_off;
          tmr <= next_tmr;
        end
      end
      assign sp = motor_bridge_pkg::step_phase(pos, C);
      // Stepper owns both halves of bridges 3 and 4 when selected
      always_comb begin
        if (stepper_sel) begin
          if (chop_off) begin
            {want_hs[2*i], want_ls[2*i]} = stepper_cfg.fast_decay ? 2'b00 : 2'b01;
            {want_hs[2*i+1], want_ls[2*i+1]} = stepper_cfg.fast_decay ? 2'b00 : 2'b01;
          end else begin
            {want_hs[2*i], want_ls[2*i]} = sp[1] ? (sp[0] ? 2'b10 : 2'b01) : 2'b00;
            {want_hs[2*i+1], want_ls[2*i+1]} = sp[1] ? (sp[0] ? 2'b01 : 2'b10) : 2'b00;
          end
        end else begin
          {want_hs[2*i], want_ls[2*i]} = soff ? 2'b00 :
            motor_bridge_pkg::half_drive(sc.mode_p, sph);
          {want_hs[2*i+1], want_ls[2*i+1]} = soff ? 2'b00 :
            motor_bridge_pkg::half_drive(sc.mode_n, sph);
        end
      end
    end else begin : g_dc
      // Plain DC bridge drive, forced off during overcurrent off-time
      always_comb begin
        {want_hs[2*i], want_ls[2*i]} = soff ? 2'b00 :
          motor_bridge_pkg::half_drive(sc.mode_p, sph);
        {want_hs[2*i+1], want_ls[2*i+1]} = soff ? 2'b00 :
          motor_bridge_pkg::half_drive(sc.mode_n, sph);
      end
    end
  end

  // Next values of shared timing, stepper, aux PWM and drive
  always_comb begin
    next_pwm_cnt = low_power ? pwm_cnt : 8'(pwm_cnt + 8'h01);
    next_step_prev = step_src;
    next_pos = pos;
    if (stepper_sel && step_rise) begin
      next_pos = stepper_cfg.dir ? 3'(pos - {~stepper_cfg.half_step, stepper_cfg.half_step})
                                 : 3'(pos + {~stepper_cfg.half_step, stepper_cfg.half_step});
    end
    next_presc = tick ? 8'h00 : 8'(presc + 8'h01);
    last = ({1'b0, pc} + 9'h001) >= {1'b0, (timed_auxiliary_pwm_button ? aux_cfg.high
                                                                     : aux_cfg.low)};
    next_pc = pc;
    next_aux = timed_auxiliary_pwm_button;
    if (tick) begin
      next_pc = last ? 8'h00 : 8'(pc + 8'h01);
      next_aux = last ? ~timed_auxiliary_pwm_button : timed_auxiliary_pwm_button;
    end
    if (low_power) begin
      next_presc = presc;
      next_pc = pc;
      next_aux = timed_auxiliary_pwm_button;
    end
    // Break before make: a switch turns on only once its partner was off
    next_hs = want_hs & en_mask & ~ls_on;
    next_ls = want_ls & en_mask & ~hs_on;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwm_cnt <= 8'h00;
      step_prev <= 1'b0;
      pos <= 3'h0;
      presc <= 8'h00;
      pc <= 8'h00;
      timed_auxiliary_pwm_button <= 1'b0;
      aux_pin_oe <= 1'b0;
      hs_on <= 8'h00;
      ls_on <= 8'h00;
      oc_level <= '0;
      stepper_vref <= 4'h0;
      switcher_controller_output <= 1'b0;
      switcher_vref <= 4'h0;
      dac_sink_pin_enable <= 1'b0;
      dac_code <= 6'h00;
      dac_lsb_sel <= 2'h0;
      dac_fs_sel <= 2'h0;
    end else begin
      pwm_cnt <= next_pwm_cnt;
      step_prev <= next_step_prev;
      pos <= next_pos;
      presc <= next_presc;
      pc <= next_pc;
      timed_auxiliary_pwm_button <= next_aux;
      aux_pin_oe <= aux_cfg.to_pin;
      hs_on <= next_hs;
      ls_on <= next_ls;
      oc_level <= oc_level_set;
      stepper_vref <= stepper_cfg.vref;
      switcher_controller_output <= switcher_cfg.enable & ~low_power &
        (pwm_cnt < switcher_cfg.duty);
      switcher_vref <= switcher_cfg.vref;
      dac_sink_pin_enable <= dac_cfg.enable & ~low_power;
      dac_code <= dac_cfg.code;
      dac_lsb_sel <= dac_cfg.lsb_sel;
      dac_fs_sel <= dac_cfg.fs_sel;
    end
  end

  // Checks on the drive, sequencing and enables
  float_till_en_a: assert property (@(posedge clk) disable iff (!nrst)
    !pair_en[0] |=> (hs_on[3:0] | ls_on[3:0]) == 4'h0) else $error("pair 1-2 drives disabled");
  static_high_a: assert property (@(posedge clk) disable iff (!nrst)
    (pair_en[0] && !low_power && !parallel_12 && !oc_busy[0] &&
     bridge_cfg[0].mode_p == motor_bridge_pkg::MODE_HIGH)[*2] |=> hs_on[0] && !ls_on[0])
    else $error("static high not driven");
  ext_src_a: assert property (@(posedge clk) disable iff (!nrst)
    bridge_cfg[0].ext_src |-> ph[0] == ext_pwm[0]) else $error("external PWM not used");
  oc_off_a: assert property (@(posedge clk) disable iff (!nrst)
    oc_trip[0] |-> ##2 (hs_on[1:0] | ls_on[1:0]) == 2'h0)
    else $error("overcurrent did not float bridge");
  pair_follow_a: assert property (@(posedge clk) disable iff (!nrst)
    parallel_12 |-> want_hs[3:2] == want_hs[1:0] && want_ls[3:2] == want_ls[1:0])
    else $error("bridge 2 not following bridge 1");
  pair34_follow_a: assert property (@(posedge clk) disable iff (!nrst)
    parallel_34 && !stepper_sel |-> want_hs[7:6] == want_hs[5:4])
    else $error("bridge 4 not following bridge 3");
  duty_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> g_bridge[0].duty == 8'h00) else $error("duty not reset");
  stepper_take_a: assert property (@(posedge clk) disable iff (!nrst)
    stepper_sel && pos == 3'h0 && !g_bridge[2].g_step.chop_off |->
    want_hs[4] && want_ls[5]) else $error("stepper not driving bridge 3");
  step_adv_a: assert property (@(posedge clk) disable iff (!nrst)
    stepper_sel && step_rise |=> pos != $past(pos)) else $error("step edge ignored");
  aux_high_a: assert property (@(posedge clk) disable iff (!nrst)
    !low_power && tick && timed_auxiliary_pwm_button && last |=> !timed_auxiliary_pwm_button)
    else $error("aux PWM high time overrun");
  sw_off_a: assert property (@(posedge clk) disable iff (!nrst)
    !switcher_cfg.enable |=> !switcher_controller_output) else $error("switcher on unbidden");
  dac_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    !dac_cfg.enable |=> !dac_sink_pin_enable) else $error("DAC sinks while disabled");
  low_power_a: assert property (@(posedge clk) disable iff (!nrst)
    low_power |=> (hs_on | ls_on) == 8'h00 && pwm_cnt == $past(pwm_cnt))
    else $error("low power not honoured");
  no_shoot_a: assert property (@(posedge clk) disable iff (!nrst)
    (hs_on & ls_on) == 8'h00) else $error("shoot-through");

  step_cover_c: cover property (@(posedge clk) disable iff (!nrst) stepper_sel && step_rise);
  pair_cover_c: cover property (@(posedge clk) disable iff (!nrst) parallel_12 && hs_on[2]);
  oc_cover_c: cover property (@(posedge clk) disable iff (!nrst) oc_trip[0] && pair_en[0]);
  aux_cover_c: cover property (@(posedge clk) disable iff (!nrst)
    $rose(timed_auxiliary_pwm_button));
endmodule : motor_bridge_output_control

// ===== testbench/drive_source_model.sv
// Model of the external PWM sources and the step clock source
`timescale 1ns/1ps
module drive_source_model (
  input wire logic clk,
  input wire logic [3:0] ext_level,
  input wire logic step_req,
  output logic [3:0] ext_pwm,
  output logic step_clock_pin
);
  int hold = 0;
  // External PWM level per bridge, held until the bench changes it
  assign ext_pwm = ext_level;
  // One step clock pulse per request: four cycles high, then low
  always @(posedge clk) begin
    if (step_req && hold == 0) begin
      hold <= 8;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end
  end
  assign step_clock_pin = (hold > 4);
endmodule : drive_source_model

// ===== testbench/tb_top.sv
// Self-checking bench of the motor bridge output control
`timescale 1ns/1ps
module tb_top;
  logic clk, nrst, parallel_12, parallel_34, stepper_sel, low_power, step_req;
  logic [1:0] pair_en, stepper_sense;
  logic [3:0] ext_level, ext_pwm, oc_trip, stepper_vref, switcher_vref;
  logic step_clock_pin, aux_out, aux_pin_oe, sw_out, dac_en;
  logic [7:0] hs_on, ls_on;
  logic [1:0][3:0] oc_level_set, oc_level;
  logic [5:0] dac_code;
  logic [1:0] dac_lsb_sel, dac_fs_sel;
  motor_bridge_pkg::bridge_cfg_t [3:0] cfg;
  motor_bridge_pkg::stepper_cfg_t st;
  motor_bridge_pkg::aux_pwm_cfg_t aux;
  motor_bridge_pkg::switcher_cfg_t sw;
  motor_bridge_pkg::dac_cfg_t dac;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int nb, ns, na, d1, d2;

  motor_bridge_output_control dut_u (.clk(clk), .nrst(nrst), .pair_en(pair_en),
    .parallel_12(parallel_12), .parallel_34(parallel_34), .stepper_sel(stepper_sel),
    .low_power(low_power), .bridge_cfg(cfg), .ext_pwm(ext_pwm), .oc_trip(oc_trip),
    .oc_level_set(oc_level_set), .stepper_cfg(st), .stepper_sense(stepper_sense),
    .step_clock_pin(step_clock_pin), .aux_cfg(aux), .switcher_cfg(sw), .dac_cfg(dac),
    .hs_on(hs_on), .ls_on(ls_on), .oc_level(oc_level), .stepper_vref(stepper_vref),
    .timed_auxiliary_pwm_button(aux_out), .aux_pin_oe(aux_pin_oe),
    .switcher_controller_output(sw_out), .switcher_vref(switcher_vref),
    .dac_sink_pin_enable(dac_en), .dac_code(dac_code), .dac_lsb_sel(dac_lsb_sel),
    .dac_fs_sel(dac_fs_sel));
  drive_source_model src_u (.clk(clk), .ext_level(ext_level), .step_req(step_req),
    .ext_pwm(ext_pwm), .step_clock_pin(step_clock_pin));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n

  function automatic motor_bridge_pkg::mode_t md(input int m);
    return motor_bridge_pkg::mode_t'(m);
  endfunction : md

  // Expected {high, low} switch state of a half-bridge
  function automatic logic [1:0] exp_half(input int m, input logic ph);
    case (m)
      0: return 2'b01;
      1: return 2'b10;
      2: return 2'b00;
      3: return ph ? 2'b10 : 2'b01;
      4: return ph ? 2'b00 : 2'b01;
      default: return ph ? 2'b10 : 2'b00;
    endcase
  endfunction : exp_half

  // Count high cycles of bridge 1 high side, switcher and aux PWM over 256 clocks
  task automatic measure();
    nb = 0;
    ns = 0;
    na = 0;
    wait_n(8);
    repeat (256) begin
      @(negedge clk);
      nb += int'(hs_on[0]);
      ns += int'(sw_out);
      na += int'(aux_out);
    end
  endtask : measure

  task automatic oc_case(input int b, input logic [1:0] off);
    cfg[b].mode_p = md(1);
    cfg[b].oc_off = off;
    wait_n(4);
    oc_trip[b] = 1'b1;
    wait_n(1);
    oc_trip[b] = 1'b0;
    wait_n((int'(off) + 1) * 40 - 10);
    chk(hs_on[2*b], 1'b0, "oc float");
    wait_n(20);
    chk(hs_on[2*b], 1'b1, "oc resume");
    cfg[b].mode_p = md(2);
  endtask : oc_case

  // Shoot-through monitor on every cycle out of reset
  always @(negedge clk) begin
    if (nrst) chk(hs_on & ls_on, 16'h0000, "shoot through");
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 6000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    {nrst, parallel_12, parallel_34, stepper_sel, low_power, step_req} = '0;
    {pair_en, stepper_sense, ext_level, oc_trip, oc_level_set} = '0;
    {cfg, st, aux, sw, dac} = '0;
    for (int b = 0; b < 4; b++) cfg[b].mode_p = md(2);
    for (int b = 0; b < 4; b++) cfg[b].mode_n = md(2);
    void'($urandom(98));
    wait_n(20);
    chk({hs_on, ls_on, 6'h00, sw_out, dac_en}, 16'h0000, "reset state");
    nrst = 1'b1;
    cfg[0].mode_p = md(1);
    wait_n(5);
    chk(hs_on, 16'h0000, "disabled pair");
    pair_en = 2'b11;
    cfg[0].ext_src = 1'b1;
    // Every mode and both PWM phases from the external source
    for (int m = 0; m < 6; m++) begin
      for (int ph = 0; ph < 2; ph++) begin
        cfg[0].mode_p = md(m);
        ext_level[0] = ph[0];
        wait_n(5);
        chk({hs_on[0], ls_on[0]}, exp_half(m, ph[0]), "half mode");
      end
    end
    // Zero duty and disabled switcher, then random duty, switcher and aux PWM
    cfg[0] = '{md(5), md(2), 1'b0, 8'h00, 2'h0};
    aux = '{8'h00, 8'h03, 8'h05, 1'b1};
    sw = '{1'b0, 8'hff, 4'h0};
    measure();
    chk(nb, 0, "zero duty");
    chk(ns, 0, "switcher off");
    chk(na, 96, "aux 3/5");
    chk(aux_pin_oe, 1'b1, "aux pin");
    d1 = $urandom_range(255, 1);
    d2 = $urandom_range(255, 1);
    cfg[0].duty = d1[7:0];
    sw = '{1'b1, d2[7:0], 4'(d1)};
    aux = '{8'h01, 8'h02, 8'h06, 1'b0};
    measure();
    chk(nb, d1, "bridge duty");
    chk(ns, d2, "switcher duty");
    chk(switcher_vref, 4'(d1), "switcher ref");
    chk(na, 64, "aux base");
    chk(aux_pin_oe, 1'b0, "aux pin off");
    // Low power floats a driven bridge and stops the switcher
    cfg[0].mode_p = md(1);
    low_power = 1'b1;
    wait_n(4);
    chk({hs_on, ls_on, 7'h00, sw_out}, 16'h0000, "low power");
    low_power = 1'b0;
    cfg[0].mode_p = md(2);
    sw.enable = 1'b0;
    // Overcurrent threshold copy and off-times
    oc_level_set = 8'($urandom);
    wait_n(3);
    chk(oc_level, oc_level_set, "oc level");
    oc_case(0, 2'h1);
    oc_case(3, 2'h0);
    // Paralleled pairs follow the lower bridge, then split again
    for (int p = 0; p < 2; p++) begin
      cfg[2*p].mode_p = md(1);
      cfg[2*p+1].mode_p = md(0);
      parallel_12 = (p == 0);
      parallel_34 = (p == 1);
      wait_n(5);
      chk({hs_on[4*p+2], ls_on[4*p+2]}, 2'b10, "parallel");
      {parallel_12, parallel_34} = 2'b00;
      wait_n(5);
      chk({hs_on[4*p+2], ls_on[4*p+2]}, 2'b01, "split");
      cfg[2*p].mode_p = md(2);
      cfg[2*p+1].mode_p = md(2);
    end
    // Stepper takes bridges 3-4 and steps on the external clock
    cfg[2].mode_p = md(1);
    st = '{1'b0, 2'h0, 2'h0, 4'($urandom), 1'b0, 1'b1, 1'b0};
    stepper_sel = 1'b1;
    wait_n(20);
    chk(stepper_vref, st.vref, "step ref");
    chk({hs_on[7:4], ls_on[7:4]}, 8'h12, "step pos 0");
    for (int k = 0; k < 3; k++) begin
      st.dir = (k > 0);
      step_req = 1'b1;
      wait_n(1);
      step_req = 1'b0;
      wait_n(20);
      if (k == 0) chk({hs_on[7:4], ls_on[7:4]}, 8'h5a, "step pos 1");
    end
    chk({hs_on[7:4], ls_on[7:4]}, 8'h96, "step pos 7");
    // Chopper off-time: slow decay both low sides on, fast decay all float
    for (int f = 0; f < 2; f++) begin
      st.fast_decay = f[0];
      stepper_sense = 2'b11;
      wait_n(4);
      stepper_sense = 2'b00;
      chk({hs_on[7:4], ls_on[7:4]}, (f == 0) ? 8'h0f : 8'h00, "chop decay");
      wait_n(60);
      chk({hs_on[7:4], ls_on[7:4]}, 8'h96, "chop end");
    end
    stepper_sel = 1'b0;
    // Current sink only while enabled
    dac = '{1'b0, 6'($urandom), 2'h1, 2'h2};
    wait_n(3);
    chk(dac_en, 1'b0, "dac off");
    dac.enable = 1'b1;
    wait_n(3);
    chk({dac_en, dac_code, dac_lsb_sel, dac_fs_sel}, dac, "dac on");
    end_sim();
  end
endmodule : tb_top
